// ==== hdl/afe_cfg_pkg.sv ====
// package: register map, field layout and reset values of the digitizer config bank
package afe_cfg_pkg;

   // ***********************************************
   // register indices (byte address = 4 * index)
   // ***********************************************
   localparam logic [7:0] red_offset_idx         = 8'h09;
   localparam logic [7:0] green_offset_idx       = 8'h0a;
   localparam logic [7:0] blue_offset_idx        = 8'h0b;
   localparam logic [7:0] offset_dac_config_idx  = 8'h0c;
   localparam logic [7:0] frontend_bandwidth_idx = 8'h0d;
   localparam logic [7:0] line_total_high_idx    = 8'h0e;
   localparam logic [7:0] line_total_low_idx     = 8'h0f;
   localparam logic [7:0] sample_phase_idx       = 8'h10;
   localparam logic [7:0] coast_before_vsync_idx = 8'h11;
   localparam logic [7:0] coast_after_vsync_idx  = 8'h12;
   localparam logic [7:0] pll_misc_control_idx   = 8'h13;
   localparam logic [7:0] black_level_ctrl_idx   = 8'h17;

   // ***********************************************
   // reset values
   // ***********************************************
   localparam logic [7:0] offset_rst             = 8'h80;
   localparam logic [7:0] offset_dac_config_rst  = 8'h00;
   localparam logic [7:0] frontend_bandwidth_rst = 8'h2e;
   localparam logic [7:0] line_total_high_rst    = 8'h03;
   localparam logic [7:0] line_total_low_rst     = 8'h20;
   localparam logic [7:0] sample_phase_rst       = 8'h00;
   localparam logic [7:0] coast_before_vsync_rst = 8'h04;
   localparam logic [7:0] coast_after_vsync_rst  = 8'h04;
   localparam logic [7:0] pll_misc_control_rst   = 8'h04;
   localparam logic [7:0] black_level_ctrl_rst   = 8'h40;

   // ***********************************************
   // field positions
   // ***********************************************
   localparam int dac_range_bit      = 0;
   localparam int red_lsb_pos        = 2;
   localparam int green_lsb_pos      = 4;
   localparam int blue_lsb_pos       = 6;
   localparam int bw_code_pos        = 1;
   localparam int peaking_pos        = 4;
   localparam int line_high_width    = 6;
   localparam int phase_width        = 6;
   localparam int lock_edge_1_bit    = 0;
   localparam int lock_edge_2_bit    = 1;
   localparam int clock_invert_input_disable_bit = 3;
   localparam int abl_disable_bit    = 0;

   // sentinel for unmapped reads
   localparam logic [31:0] unmapped_read = 32'h0000_0000;

   // ***********************************************
   // carrier types
   // ***********************************************
   typedef struct packed {
      logic [9:0] red;
      logic [9:0] green;
      logic [9:0] blue;
   } dac_triplet_t;

   typedef struct packed {
      logic signed [8:0] red;
      logic signed [8:0] green;
      logic signed [8:0] blue;
   } digital_offset_t;

   typedef struct packed {
      logic [13:0] line_total;
      logic [5:0]  sample_phase;
      logic [7:0]  coast_before;
      logic [7:0]  coast_after;
      logic        lead_edge_first;
      logic        lead_edge_second;
   } pll_cfg_t;

   typedef enum logic [1:0] {
      bus_idle,
      bus_ack
   } bus_state_t;

endpackage

// ==== hdl/video_afe_offset_pll_config_regs.sv ====
// module: configuration register bank for offset, bandwidth and digital pll controls
`timescale 1ns/1ps
module video_afe_offset_pll_config_regs
   import afe_cfg_pkg::*;
(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                srst,
   // avalon-mm slave
   input  wire logic [9:0]          address,
   input  wire logic                read,
   input  wire logic                write,
   input  wire logic [31:0]         writedata,
   input  wire logic [3:0]          byteenable,
   output logic [31:0]              readdata,
   output logic                     waitrequest,
   // clamp source and pins
   input  wire logic                external_clamp_select,
   input  wire logic                clamp_pulse,
   input  wire logic                clock_invert_input,
   // analog and pll controls
   output dac_triplet_t             offset_dac,
   output logic                     offset_dac_half_range,
   output digital_offset_t          digital_offset,
   output logic                     auto_black_level_loop,
   output logic [2:0]               frontend_bandwidth_code,
   output logic [3:0]               peaking_code,
   output pll_cfg_t                 pll_cfg,
   output logic                     clock_invert_effective
);

   // ***********************************************
   // register storage
   // ***********************************************
   logic [7:0]   red_offset_reg;
   logic [7:0]   green_offset_reg;
   logic [7:0]   blue_offset_reg;
   logic [7:0]   offset_dac_config_reg;
   logic [7:0]   frontend_bandwidth_reg;
   logic [7:0]   line_total_high_reg;
   logic [7:0]   line_total_low_reg;
   logic [7:0]   sample_phase_reg;
   logic [7:0]   coast_before_vsync_reg;
   logic [7:0]   coast_after_vsync_reg;
   logic [7:0]   pll_misc_control_reg;
   logic [7:0]   black_level_ctrl_reg;
   logic [13:0]  line_total_reg;
   logic         clamp_prev_reg;
   bus_state_t   bus_state_reg;
   logic [31:0]  readdata_reg;

   logic [7:0]   index;
   logic         word_ok;
   logic         wr_take;
   logic         rd_take;
   logic         lane0;
   logic [7:0]   wbyte;
   logic [7:0]   rd_value;
   logic         rd_hit;
   logic         dac_update;

   // ***********************************************
   // helpers
   // ***********************************************
   function automatic logic [9:0] dac_word(input logic [7:0] upper, input logic [1:0] lower);
      dac_word = {upper, lower};
   endfunction

   // offset binary to two's complement, -0x80 .. +0x7f
   function automatic logic signed [8:0] to_signed(input logic [7:0] code);
      to_signed = $signed({1'b0, code}) - 9'sd128;
   endfunction

   // ***********************************************
   // avalon-mm handshake
   // ***********************************************
   // one wait cycle: read sampled in idle, write commits in the answer cycle
   assign index       = address[9:2];
   assign word_ok     = (address[1:0] == 2'b00);
   assign lane0       = byteenable[0];
   assign wbyte       = writedata[7:0];
   assign wr_take     = write && (bus_state_reg == bus_ack);
   assign rd_take     = read && (bus_state_reg == bus_idle);
   assign waitrequest = (read || write) && (bus_state_reg == bus_idle);

   always_ff @(posedge clock) begin
      if (srst) begin
         bus_state_reg <= bus_idle;
      end else begin
         case (bus_state_reg)
            bus_idle: begin
               if (read || write) begin
                  bus_state_reg <= bus_ack;
               end
            end
            default: begin
               bus_state_reg <= bus_idle;
            end
         endcase
      end
   end

   // ***********************************************
   // register writes
   // ***********************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         red_offset_reg         <= offset_rst;
         green_offset_reg       <= offset_rst;
         blue_offset_reg        <= offset_rst;
         offset_dac_config_reg  <= offset_dac_config_rst;
         frontend_bandwidth_reg <= frontend_bandwidth_rst;
         line_total_high_reg    <= line_total_high_rst;
         line_total_low_reg     <= line_total_low_rst;
         sample_phase_reg       <= sample_phase_rst;
         coast_before_vsync_reg <= coast_before_vsync_rst;
         coast_after_vsync_reg  <= coast_after_vsync_rst;
         pll_misc_control_reg   <= pll_misc_control_rst;
         black_level_ctrl_reg   <= black_level_ctrl_rst;
      end else if (wr_take && word_ok && lane0) begin
         if (index == red_offset_idx) begin
            red_offset_reg <= wbyte;
         end else if (index == green_offset_idx) begin
            green_offset_reg <= wbyte;
         end else if (index == blue_offset_idx) begin
            blue_offset_reg <= wbyte;
         end else if (index == offset_dac_config_idx) begin
            offset_dac_config_reg <= wbyte;
         end else if (index == frontend_bandwidth_idx) begin
            frontend_bandwidth_reg <= wbyte;
         end else if (index == line_total_high_idx) begin
            line_total_high_reg <= wbyte;
         end else if (index == line_total_low_idx) begin
            line_total_low_reg <= wbyte;
         end else if (index == sample_phase_idx) begin
            sample_phase_reg <= wbyte;
         end else if (index == coast_before_vsync_idx) begin
            coast_before_vsync_reg <= wbyte;
         end else if (index == coast_after_vsync_idx) begin
            coast_after_vsync_reg <= wbyte;
         end else if (index == pll_misc_control_idx) begin
            pll_misc_control_reg <= wbyte;
         end else if (index == black_level_ctrl_idx) begin
            black_level_ctrl_reg <= wbyte;
         end
      end
   end

   // ***********************************************
   // pll line total, latched on low write only
   // ***********************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         line_total_reg <= {line_total_high_rst[line_high_width-1:0], line_total_low_rst};
      end else if (wr_take && word_ok && lane0 && index == line_total_low_idx) begin
         line_total_reg <= {line_total_high_reg[line_high_width-1:0], wbyte};
      end
   end

   // ***********************************************
   // offset dac update point
   // ***********************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         clamp_prev_reg <= 1'b0;
      end else begin
         clamp_prev_reg <= clamp_pulse;
      end
   end

   // internal clamp: follow at once; external: at clamp rising edge
   assign dac_update = !external_clamp_select || (clamp_pulse && !clamp_prev_reg);

   always_ff @(posedge clock) begin
      if (srst) begin
         offset_dac.red        <= dac_word(offset_rst, 2'b00);
         offset_dac.green      <= dac_word(offset_rst, 2'b00);
         offset_dac.blue       <= dac_word(offset_rst, 2'b00);
         offset_dac_half_range <= 1'b0;
      end else if (dac_update) begin
         offset_dac.red   <= dac_word(red_offset_reg,
                                      offset_dac_config_reg[red_lsb_pos +: 2]);
         offset_dac.green <= dac_word(green_offset_reg,
                                      offset_dac_config_reg[green_lsb_pos +: 2]);
         offset_dac.blue  <= dac_word(blue_offset_reg,
                                      offset_dac_config_reg[blue_lsb_pos +: 2]);
         offset_dac_half_range <= offset_dac_config_reg[dac_range_bit];
      end
   end

   // ***********************************************
   // control outputs
   // ***********************************************
   always_ff @(posedge clock) begin
      if (srst) begin
         auto_black_level_loop <= 1'b1;
         digital_offset        <= '0;
      end else begin
         auto_black_level_loop <= !black_level_ctrl_reg[abl_disable_bit];
         if (!black_level_ctrl_reg[abl_disable_bit]) begin
            digital_offset.red   <= to_signed(red_offset_reg);
            digital_offset.green <= to_signed(green_offset_reg);
            digital_offset.blue  <= to_signed(blue_offset_reg);
         end else begin
            digital_offset <= '0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         frontend_bandwidth_code <= frontend_bandwidth_rst[bw_code_pos +: 3];
         peaking_code            <= frontend_bandwidth_rst[peaking_pos +: 4];
         clock_invert_effective  <= 1'b0;
      end else begin
         frontend_bandwidth_code <= frontend_bandwidth_reg[bw_code_pos +: 3];
         peaking_code            <= frontend_bandwidth_reg[peaking_pos +: 4];
         clock_invert_effective  <= clock_invert_input &&
                                    !pll_misc_control_reg[clock_invert_input_disable_bit];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         pll_cfg.line_total       <= {line_total_high_rst[line_high_width-1:0], line_total_low_rst};
         pll_cfg.sample_phase     <= sample_phase_rst[phase_width-1:0];
         pll_cfg.coast_before     <= coast_before_vsync_rst;
         pll_cfg.coast_after      <= coast_after_vsync_rst;
         pll_cfg.lead_edge_first  <= pll_misc_control_rst[lock_edge_1_bit];
         pll_cfg.lead_edge_second <= pll_misc_control_rst[lock_edge_2_bit];
      end else begin
         pll_cfg.line_total       <= line_total_reg;
         pll_cfg.sample_phase     <= sample_phase_reg[phase_width-1:0];
         pll_cfg.coast_before     <= coast_before_vsync_reg;
         pll_cfg.coast_after      <= coast_after_vsync_reg;
         pll_cfg.lead_edge_first  <= pll_misc_control_reg[lock_edge_1_bit];
         pll_cfg.lead_edge_second <= pll_misc_control_reg[lock_edge_2_bit];
      end
   end

   // ***********************************************
   // read path
   // ***********************************************
   always_comb begin
      rd_hit   = 1'b1;
      rd_value = 8'h00;
      if (index == red_offset_idx) begin
         rd_value = red_offset_reg;
      end else if (index == green_offset_idx) begin
         rd_value = green_offset_reg;
      end else if (index == blue_offset_idx) begin
         rd_value = blue_offset_reg;
      end else if (index == offset_dac_config_idx) begin
         rd_value = offset_dac_config_reg;
      end else if (index == frontend_bandwidth_idx) begin
         rd_value = frontend_bandwidth_reg;
      end else if (index == line_total_high_idx) begin
         rd_value = line_total_high_reg;
      end else if (index == line_total_low_idx) begin
         rd_value = line_total_low_reg;
      end else if (index == sample_phase_idx) begin
         rd_value = sample_phase_reg;
      end else if (index == coast_before_vsync_idx) begin
         rd_value = coast_before_vsync_reg;
      end else if (index == coast_after_vsync_idx) begin
         rd_value = coast_after_vsync_reg;
      end else if (index == pll_misc_control_idx) begin
         rd_value = pll_misc_control_reg;
      end else if (index == black_level_ctrl_idx) begin
         rd_value = black_level_ctrl_reg;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         readdata_reg <= '0;
      end else if (rd_take) begin
         readdata_reg <= (rd_hit && word_ok) ? {24'h000000, rd_value} : unmapped_read;
      end
   end

   assign readdata = readdata_reg;

endmodule // video_afe_offset_pll_config_regs

// ==== tb/afe_cfg_checker.sv ====
// checker: bus handshake and output relations of the config bank
`timescale 1ns/1ps
module afe_cfg_checker
   import afe_cfg_pkg::*;
(
   // clock, reset and bus
   input wire logic            clock,
   input wire logic            srst,
   input wire logic [9:0]      address,
   input wire logic            read,
   input wire logic            write,
   input wire logic [31:0]     readdata,
   input wire logic            waitrequest,
   // pins and controls
   input wire logic            external_clamp_select,
   input wire logic            clamp_pulse,
   input wire logic            clock_invert_input,
   input wire dac_triplet_t    offset_dac,
   input wire digital_offset_t digital_offset,
   input wire logic            auto_black_level_loop,
   input wire logic [2:0]      frontend_bandwidth_code,
   input wire pll_cfg_t        pll_cfg,
   input wire logic            clock_invert_effective
);
   // ****************
   // write history
   // ****************
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   logic [2:0] wr_hist;
   logic [2:0] lo_hist;
   always_ff @(posedge clock) begin
      wr_hist <= {wr_hist[1:0], write};
   end
   always_ff @(posedge clock) begin
      lo_hist <= {lo_hist[1:0], write && address == 10'h03c};
   end
   // ****************
   // properties
   // ****************
   wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one cycle");
   idle_ready_a: assert property (!read && !write |-> !waitrequest)
      else $error("waitrequest high while idle");
   read_upper_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   read_hold_a: assert property (!read |=> $stable(readdata))
      else $error("read data moved without a read");
   clock_invert_input_pin_a: assert property (clock_invert_effective |-> $past(clock_invert_input))
      else $error("clock invert high without pin");
   loop_off_a: assert property (!auto_black_level_loop |-> digital_offset == '0)
      else $error("digital offset active with loop off");
   digital_match_a: assert property (auto_black_level_loop && !external_clamp_select
      && $stable(offset_dac) && $stable(digital_offset)
      |-> digital_offset.red == $signed({1'b0, offset_dac.red[9:2]}) - 9'sd128)
      else $error("digital offset not offset binary");
   clamp_hold_a: assert property (external_clamp_select && $past(external_clamp_select)
      && $past(external_clamp_select, 2) && !clamp_pulse && !$past(clamp_pulse)
      && !$past(clamp_pulse, 2) |-> $stable(offset_dac))
      else $error("dac moved without clamp edge");
   total_hold_a: assert property (!$past(srst) && $changed(pll_cfg.line_total)
      |-> lo_hist != 3'b000)
      else $error("line total moved without low write");
   cfg_cause_a: assert property (!$past(srst)
      && ($changed(pll_cfg) || $changed(frontend_bandwidth_code)) |-> wr_hist != 3'b000)
      else $error("config output moved without write");
   cover property (write && !waitrequest);
   cover property (external_clamp_select && $rose(clamp_pulse));
   cover property (!auto_black_level_loop);
endmodule // afe_cfg_checker

bind video_afe_offset_pll_config_regs afe_cfg_checker i_afe_cfg_checker (.clock, .srst,
   .address, .read, .write, .readdata, .waitrequest, .external_clamp_select, .clamp_pulse,
   .clock_invert_input, .offset_dac, .digital_offset, .auto_black_level_loop,
   .frontend_bandwidth_code, .pll_cfg, .clock_invert_effective);

// ==== tb/video_afe_offset_pll_config_regs_tb_top.sv ====
// testbench: random and corner register traffic with output checks
`timescale 1ns/1ps
module video_afe_offset_pll_config_regs_tb_top;
   import afe_cfg_pkg::*;
   // ****************
   // signals
   // ****************
   logic clock = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
   logic [9:0] address = 10'h0;
   logic [31:0] writedata = 32'h0, readdata, rd, seed = 32'h874c;
   logic [3:0] byteenable = 4'h0, peaking_code;
   logic external_clamp_select = 1'b0, clamp_pulse = 1'b0, clock_invert_input = 1'b0;
   logic waitrequest, offset_dac_half_range, auto_black_level_loop, clock_invert_effective;
   logic [2:0] frontend_bandwidth_code;
   dac_triplet_t offset_dac, old;
   digital_offset_t digital_offset;
   pll_cfg_t pll_cfg;
   logic [7:0] shadow [0:31];
   logic [13:0] total_exp;
   int n_errors = 0, n_tests = 0;
   always #2.5 clock = ~clock;
   video_afe_offset_pll_config_regs i_video_afe_offset_pll_config_regs (.clock, .srst,
      .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
      .external_clamp_select, .clamp_pulse, .clock_invert_input, .offset_dac,
      .offset_dac_half_range, .digital_offset, .auto_black_level_loop,
      .frontend_bandwidth_code, .peaking_code, .pll_cfg, .clock_invert_effective);
   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] idx_of(input int r);
      return (r == 11) ? 8'h17 : 8'h09 + 8'(r);
   endfunction
   function automatic logic [7:0] rst_val(input int k);
      case (k)
         9, 10, 11: return 8'h80;
         13: return 8'h2e;
         14: return 8'h03;
         15: return 8'h20;
         17, 18, 19: return 8'h04;
         23: return 8'h40;
         default: return 8'h00;
      endcase
   endfunction
   function automatic logic [7:0] legal(input logic [7:0] idx, input logic [7:0] d);
      case (idx)
         8'h0c, 8'h17: return d & 8'hfd;
         8'h0d: return {2'b00, d[5] & ~d[4], d[4], d[3:0]};
         8'h0e: return d | 8'h02;
         8'h13: return d & 8'h0b;
         default: return d;
      endcase
   endfunction
   function automatic dac_triplet_t exp_dac();
      return {shadow[9], shadow[12][3:2], shadow[10], shadow[12][5:4],
              shadow[11], shadow[12][7:6]};
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bus_xfer(input logic we, input logic [7:0] idx, input logic [7:0] d,
                           input logic [3:0] be, output logic [31:0] q);
      int i;
      address <= {idx, 2'b00};
      writedata <= {24'h0, d};
      byteenable <= be;
      write <= we;
      read <= ~we;
      for (i = 0; i < 40; i++) begin
         @(posedge clock);
         if (waitrequest === 1'b0) break;
      end
      if (i == 40) n_errors++;
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bus_xfer(1'b1, idx, d, 4'h1, rd);
      shadow[idx[4:0]] = d;
      if (idx == 8'h0f) total_exp = {shadow[14][5:0], d};
   endtask
   task automatic rd_chk(input logic [7:0] idx);
      logic [7:0] e;
      e = (idx inside {[8'h09:8'h13], 8'h17}) ? shadow[idx[4:0]] : 8'h00;
      bus_xfer(1'b0, idx, 8'h00, 4'h0, rd);
      check(rd, {56'h0, e});
   endtask
   task automatic reset_model;
      for (int k = 0; k < 32; k++) shadow[k] = rst_val(k);
      total_exp = 14'h0320;
      @(posedge clock);
      for (int r = 0; r < 12; r++) rd_chk(idx_of(r));
   endtask
   task automatic chk_out;
      logic lp;
      logic [26:0] g;
      lp = ~shadow[23][0];
      g = lp ? {{1'b0, shadow[9]} - 9'h080, {1'b0, shadow[10]} - 9'h080,
                {1'b0, shadow[11]} - 9'h080} : 27'h0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      check(64'(offset_dac), 64'(exp_dac()));
      check(64'(offset_dac_half_range), 64'(shadow[12][0]));
      check(64'(auto_black_level_loop), 64'(lp));
      check(64'(digital_offset), 64'(g));
      check(64'({frontend_bandwidth_code, peaking_code}), 64'({shadow[13][3:1], shadow[13][7:4]}));
      check(64'(pll_cfg), 64'({total_exp, shadow[16][5:0], shadow[17], shadow[18],
            shadow[19][0], shadow[19][1]}));
      check(64'(clock_invert_effective), 64'(clock_invert_input & ~shadow[19][3]));
      @(posedge clock);
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      #100us;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      reset_model;
      chk_out;
      rd_chk(8'h20);
      bus_xfer(1'b1, 8'h09, 8'h11, 4'h0, rd);
      rd_chk(8'h09);
      wr(8'h0e, 8'h3f);
      chk_out;
      wr(8'h0f, 8'h00);
      chk_out;
      for (int i = 0; i < 300; i++) begin
         seed = xs(seed);
         clock_invert_input <= seed[20];
         wr(idx_of(int'(seed % 12)), legal(idx_of(int'(seed % 12)), seed[15:8]));
         rd_chk(idx_of(int'(seed % 12)));
         chk_out;
      end
      external_clamp_select <= 1'b1;
      old = exp_dac();
      wr(8'h09, 8'h5a);
      wr(8'h0c, 8'hc4);
      repeat (3) @(posedge clock);
      check(64'(offset_dac), 64'(old));
      clamp_pulse <= 1'b1;
      @(posedge clock);
      clamp_pulse <= 1'b0;
      repeat (3) @(posedge clock);
      check(64'(offset_dac), 64'(exp_dac()));
      external_clamp_select <= 1'b0;
      chk_out;
      srst <= 1'b1;
      repeat (2) @(posedge clock);
      srst <= 1'b0;
      reset_model;
      chk_out;
      tally_and_finish;
   end
endmodule // video_afe_offset_pll_config_regs_tb_top
